// *** rtl/wte_dac_sel.sv ***
/*
 * Converter feed: picks the synthesizer mix or the processor word and
 * registers it together with the converter power level.
 * Assumes the mix word is steady between sample periods.
 */
`default_nettype none
module wte_dac_sel (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic ce,
  // Sources
  input wire logic [15:0] mix,
  input wire wte_pkg::wte_dac_t dac_cfg,
  // Converter
  output logic dac_on,
  output logic [15:0] dac_word
);
  typedef struct packed {
    logic on;
    logic [15:0] word;
  } wte_dsel_st_t;

  wte_dsel_st_t s_r, s_nxt;

  // Source select; the word still updates while powered down
  always_comb begin
    s_nxt.on = dac_cfg.on;
    s_nxt.word = dac_cfg.src ? mix : dac_cfg.word;
  end

  // Output register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign dac_on = s_r.on;
  assign dac_word = s_r.word;

  source_sel_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ce && dac_cfg.src |=> dac_word == $past(mix) ##1
    (!$past(ce) || $past(dac_cfg.src) ||
    dac_word == $past(dac_cfg.word)))
    else $error("converter source select wrong");
endmodule : wte_dac_sel
`default_nettype wire

// *** rtl/wte_pkg.sv ***
/*
 * Shared constants and types of the wavetable voice engine: register
 * offsets, field positions, timing counts and the carrier structs.
 * Assumes one 200 MHz clock domain and an 8-bit processor data port.
 */
`default_nettype none
package wte_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned SAMPLE_HZ = 25_000;
  localparam int unsigned SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;
  localparam int unsigned NUM_VOICES = 8;
  localparam int unsigned MIN_PERIOD = 64; // Room for eight voice slots

  // ---------------------------------------------------------------
  // Register offsets in processor data memory
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_WORD_HI = 8'h1d;
  localparam logic [7:0] ADDR_WORD_LO = 8'h1e;
  localparam logic [7:0] ADDR_CTL = 8'h1f;
  localparam logic [7:0] ADDR_TRIG = 8'h20;
  localparam logic [7:0] ADDR_OCT_PITCH = 8'h21;
  localparam logic [7:0] ADDR_PITCH_LO = 8'h22;
  localparam logic [7:0] ADDR_ORG_HI = 8'h23;
  localparam logic [7:0] ADDR_ORG_LO = 8'h24;
  localparam logic [7:0] ADDR_WID_LOOP = 8'h25;
  localparam logic [7:0] ADDR_LOOP_LO = 8'h26;
  localparam logic [7:0] ADDR_ATT_HI = 8'h27;
  localparam logic [7:0] ADDR_ATT_LO = 8'h2a;

  // ---------------------------------------------------------------
  // Field positions and codes
  // ---------------------------------------------------------------
  localparam int unsigned CTL_SRC_BIT = 0;
  localparam int unsigned CTL_ON_BIT = 1;
  localparam int unsigned WID_BIT = 7;
  localparam int unsigned FRAC_W = 17;       // Step is pitch / 2^(17-oct)
  localparam int unsigned POS_W = 16;
  localparam int unsigned PHASE_W = POS_W + FRAC_W;
  localparam int unsigned ORIGIN_SHIFT = 5;  // Origin lands in bits 15:5
  localparam int unsigned GAIN_SHIFT = 9;
  localparam logic [7:0] END_CODE = 8'h80;
  localparam logic [9:0] ATT_MIN = 10'h3ff;
  localparam logic [5:0] LOOP_FILL = 6'h3f;  // Loop field is negative

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    UPD_ALL = 2'b00,
    UPD_PITCH = 2'b01,
    UPD_VOL = 2'b10,
    UPD_RSVD = 2'b11
  } wte_upd_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } wte_bus_t;

  typedef struct packed {
    logic valid;
    wte_upd_t mode;
    logic [2:0] voice;
  } wte_trig_t;

  typedef struct packed {
    logic [3:0] oct;
    logic [11:0] pitch;
    logic [10:0] origin;
    logic wide;
    logic [9:0] loop;
    logic [9:0] atten;
  } wte_param_t;

  typedef struct packed {
    logic on;
    logic src;
    logic [15:0] word;
  } wte_dac_t;
endpackage : wte_pkg
`default_nettype wire

// *** rtl/wte_regs.sv ***
/*
 * Processor-facing register file of the voice engine: stores the used
 * bits of each mapped byte, returns them on read and pulses a trigger on voice-select write.
 * Assumes single-cycle write and read strobes from the processor.
 */
`default_nettype none
module wte_regs (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic ce,
  // Processor data-memory port
  input wire wte_pkg::wte_bus_t bus,
  output logic [7:0] rdata,
  // Towards engine and converter
  output wte_pkg::wte_param_t param,
  output wte_pkg::wte_trig_t trig,
  output wte_pkg::wte_dac_t dac_cfg
);
  typedef struct packed {
    logic [7:0] w_hi;
    logic [7:0] w_lo;
    logic [1:0] ctl;
    logic [7:0] sel;
    logic [7:0] oct_pitch;
    logic [7:0] pitch_lo;
    logic [2:0] org_hi;
    logic [7:0] org_lo;
    logic wid;
    logic [1:0] loop_hi;
    logic [7:0] loop_lo;
    logic [1:0] att_hi;
    logic [7:0] att_lo;
    logic [7:0] rdata;
    wte_pkg::wte_trig_t trig;
  } wte_regs_st_t;

  wte_regs_st_t s_r, s_nxt;

  // Read mux; unused bits and unmapped offsets read as zero
  function automatic logic [7:0] read_reg(input wte_regs_st_t s,
                                          input logic [7:0] a);
    case (a)
      wte_pkg::ADDR_WORD_HI: read_reg = s.w_hi;
      wte_pkg::ADDR_WORD_LO: read_reg = s.w_lo;
      wte_pkg::ADDR_CTL: read_reg = {6'h00, s.ctl};
      wte_pkg::ADDR_TRIG: read_reg = s.sel;
      wte_pkg::ADDR_OCT_PITCH: read_reg = s.oct_pitch;
      wte_pkg::ADDR_PITCH_LO: read_reg = s.pitch_lo;
      wte_pkg::ADDR_ORG_HI: read_reg = {5'h00, s.org_hi};
      wte_pkg::ADDR_ORG_LO: read_reg = s.org_lo;
      wte_pkg::ADDR_WID_LOOP: read_reg = {s.wid, 5'h00, s.loop_hi};
      wte_pkg::ADDR_LOOP_LO: read_reg = s.loop_lo;
      wte_pkg::ADDR_ATT_HI: read_reg = {6'h00, s.att_hi};
      wte_pkg::ADDR_ATT_LO: read_reg = s.att_lo;
      default: read_reg = 8'h00;
    endcase
  endfunction : read_reg

  // Byte stores; a voice-select write raises the trigger for one cycle
  always_comb begin
    s_nxt = s_r;
    s_nxt.trig.valid = 1'b0;
    if (bus.re) begin
      s_nxt.rdata = read_reg(s_r, bus.addr);
    end
    if (bus.we) begin
      case (bus.addr)
        wte_pkg::ADDR_WORD_HI: s_nxt.w_hi = bus.wdata;
        wte_pkg::ADDR_WORD_LO: s_nxt.w_lo = bus.wdata;
        wte_pkg::ADDR_CTL: s_nxt.ctl = bus.wdata[1:0];
        wte_pkg::ADDR_TRIG: begin
          s_nxt.sel = {bus.wdata[7:6], 3'h0, bus.wdata[2:0]};
          s_nxt.trig.valid = 1'b1;
          s_nxt.trig.mode = wte_pkg::wte_upd_t'(bus.wdata[7:6]);
          s_nxt.trig.voice = bus.wdata[2:0];
        end
        wte_pkg::ADDR_OCT_PITCH: s_nxt.oct_pitch = bus.wdata;
        wte_pkg::ADDR_PITCH_LO: s_nxt.pitch_lo = bus.wdata;
        wte_pkg::ADDR_ORG_HI: s_nxt.org_hi = bus.wdata[2:0];
        wte_pkg::ADDR_ORG_LO: s_nxt.org_lo = bus.wdata;
        wte_pkg::ADDR_WID_LOOP: begin
          s_nxt.wid = bus.wdata[wte_pkg::WID_BIT];
          s_nxt.loop_hi = bus.wdata[1:0];
        end
        wte_pkg::ADDR_LOOP_LO: s_nxt.loop_lo = bus.wdata;
        wte_pkg::ADDR_ATT_HI: s_nxt.att_hi = bus.wdata[1:0];
        wte_pkg::ADDR_ATT_LO: s_nxt.att_lo = bus.wdata;
        default: ;
      endcase
    end
  end

  // State register; converter comes out of reset powered down
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign rdata = s_r.rdata;
  assign trig = s_r.trig;
  assign param = '{oct: s_r.oct_pitch[7:4],
                   pitch: {s_r.oct_pitch[3:0], s_r.pitch_lo},
                   origin: {s_r.org_hi, s_r.org_lo},
                   wide: s_r.wid,
                   loop: {s_r.loop_hi, s_r.loop_lo},
                   atten: {s_r.att_hi, s_r.att_lo}};
  assign dac_cfg = '{on: s_r.ctl[wte_pkg::CTL_ON_BIT],
                     src: s_r.ctl[wte_pkg::CTL_SRC_BIT],
                     word: {s_r.w_hi, s_r.w_lo}};

  trig_pulse_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ce && bus.we && bus.addr == wte_pkg::ADDR_TRIG |=> trig.valid &&
    trig.voice == $past(bus.wdata[2:0]) ##1 (!$past(ce) || !trig.valid ||
    $past(ce && bus.we && bus.addr == wte_pkg::ADDR_TRIG)))
    else $error("trigger pulse wrong");
  power_bit_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ce && bus.we && bus.addr == wte_pkg::ADDR_CTL |=>
    dac_cfg.on == $past(bus.wdata[wte_pkg::CTL_ON_BIT]))
    else $error("converter power bit not stored");
  power_reset_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $rose(arst_n) |-> !dac_cfg.on)
    else $error("converter on after reset");
  word_high_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ce && bus.we && bus.addr == wte_pkg::ADDR_WORD_HI |=>
    dac_cfg.word[15:8] == $past(bus.wdata) && $stable(dac_cfg.word[7:0]))
    else $error("converter word high byte wrong");
endmodule : wte_regs
`default_nettype wire

// *** rtl/wte_synth.sv ***
/*
 * Eight-voice wavetable engine top: register file, voice table, ROM
 * sample fetch, attenuation and mix, and the converter feed.
 * Assumes a shared ROM port that answers each request with an ack.
 */
`default_nettype none
module wte_synth #(
  parameter int unsigned SAMPLE_PERIOD = wte_pkg::SAMPLE_CYCLES
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic ce,
  // Processor data-memory port
  input wire wte_pkg::wte_bus_t bus,
  output logic [7:0] bus_rdata,
  // Shared program ROM fetch port
  output logic rom_req,
  output logic [15:0] rom_addr,
  input wire logic rom_ack,
  input wire logic [15:0] rom_data,
  // Converter
  output logic dac_on,
  output logic [15:0] dac_word
);
  // ---------------------------------------------------------------
  // Types and checks
  // ---------------------------------------------------------------
  localparam int unsigned CNT_W = $clog2(SAMPLE_PERIOD);
  localparam int unsigned PW = wte_pkg::PHASE_W;
  localparam int unsigned FW = wte_pkg::FRAC_W;

  if (SAMPLE_PERIOD < wte_pkg::MIN_PERIOD) begin : g_bad_period
    $error("sample period too short for eight voices");
  end

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_FETCH_A = 3'b001,
    S_FETCH_B = 3'b010,
    S_EVAL = 3'b011,
    S_DONE = 3'b100
  } wte_seq_t;

  typedef struct packed {
    logic active;
    wte_pkg::wte_param_t p;
    logic [PW-1:0] phase;
  } wte_voice_t;

  typedef struct packed {
    wte_voice_t [wte_pkg::NUM_VOICES-1:0] v;
    wte_seq_t seq;
    logic [2:0] cur;
    logic retried;
    logic lane;
    logic [7:0] byte_a;
    logic [3:0] nib;
    logic signed [15:0] acc;
    logic [15:0] mix;
    logic [CNT_W-1:0] cnt;
    logic req;
    logic [15:0] addr;
  } wte_eng_t;

  wte_eng_t s_r, s_nxt;
  wte_pkg::wte_param_t param;
  wte_pkg::wte_trig_t trig;
  wte_pkg::wte_dac_t dac_cfg;
  wte_voice_t cur_v;
  logic [15:0] cur_pos;
  logic [15:0] loop_tgt;
  logic [7:0] got;
  logic signed [13:0] contrib;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Byte address of a sample; in 12-bit mode each pair of samples
  // takes three bytes: high+middle of the even one, of the odd one,
  // then both low nibbles (even in the upper half)
  function automatic logic [16:0] byte_addr(input logic [10:0] origin,
                                            input logic wide,
                                            input logic [15:0] pos,
                                            input logic low_nib);
    logic [16:0] base;
    logic [16:0] off;
    base = 17'(origin) << (wte_pkg::ORIGIN_SHIFT + 1);
    if (!wide) begin
      off = 17'(pos);
    end else begin
      off = 17'h3 * 17'(pos[15:1]) + (low_nib ? 17'h2 : 17'(pos[0]));
    end
    byte_addr = base + off;
  endfunction : byte_addr

  // High byte of a ROM word comes first in the sample stream
  function automatic logic [7:0] byte_of(input logic [15:0] w,
                                         input logic lane);
    byte_of = lane ? w[7:0] : w[15:8];
  endfunction : byte_of

  // Linear gain of (all-ones minus attenuation), so all-ones is silent
  function automatic logic signed [13:0] attenuate(
      input logic signed [11:0] smp, input logic [9:0] att);
    logic signed [22:0] prod;
    logic signed [22:0] sh;
    prod = smp * $signed({1'b0, wte_pkg::ATT_MIN - att});
    sh = prod >>> wte_pkg::GAIN_SHIFT;
    attenuate = sh[13:0];
  endfunction : attenuate

  // ---------------------------------------------------------------
  // Register file and converter feed
  // ---------------------------------------------------------------
  wte_regs u_regs (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .ce(ce),
    .bus(bus),
    .rdata(bus_rdata),
    .param(param),
    .trig(trig),
    .dac_cfg(dac_cfg)
  );

  wte_dac_sel u_dac (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .ce(ce),
    .mix(s_r.mix),
    .dac_cfg(dac_cfg),
    .dac_on(dac_on),
    .dac_word(dac_word)
  );

  // ---------------------------------------------------------------
  // Voice sequencer
  // ---------------------------------------------------------------
  // Current voice view; the loop field is sign-filled so the add
  // wraps back and any carry out of the top is dropped
  assign cur_v = s_r.v[s_r.cur];
  assign cur_pos = cur_v.phase[PW-1:FW];
  assign loop_tgt = cur_pos + {wte_pkg::LOOP_FILL, cur_v.p.loop};
  assign got = byte_of(rom_data, s_r.lane);
  assign contrib = attenuate(cur_v.p.wide ? {s_r.byte_a, s_r.nib} :
                             {s_r.byte_a, 4'h0}, cur_v.p.atten);

  // One pass over all voices per output period; a pass still running
  // at the period tick makes that tick be skipped (slow ROM only)
  always_comb begin
    logic [16:0] ba;
    logic to_next;
    ba = '0;
    to_next = 1'b0;
    s_nxt = s_r;
    s_nxt.cnt = (s_r.cnt == '0) ? CNT_W'(SAMPLE_PERIOD - 1) :
                s_r.cnt - CNT_W'(1);
    unique case (s_r.seq)
      S_IDLE: begin
        if (s_r.cnt == '0) begin
          s_nxt.cur = 3'h0;
          s_nxt.acc = '0;
          s_nxt.retried = 1'b0;
          s_nxt.seq = S_FETCH_A;
        end
      end
      S_FETCH_A: begin
        if (!s_r.req) begin
          if (!cur_v.active || cur_v.p.atten == wte_pkg::ATT_MIN) begin
            s_nxt.v[s_r.cur].active = 1'b0;
            to_next = 1'b1;
          end else begin
            ba = byte_addr(cur_v.p.origin, cur_v.p.wide, cur_pos, 1'b0);
            s_nxt.req = 1'b1;
            s_nxt.addr = ba[16:1];
            s_nxt.lane = ba[0];
          end
        end else if (rom_ack) begin
          s_nxt.req = 1'b0;
          s_nxt.byte_a = got;
          if (got == wte_pkg::END_CODE) begin
            if (s_r.retried) begin
              to_next = 1'b1; // Loop lands on an end code: stay silent
            end else begin
              s_nxt.retried = 1'b1;
              s_nxt.v[s_r.cur].phase[PW-1:FW] = loop_tgt;
            end
          end else if (cur_v.p.wide) begin
            s_nxt.seq = S_FETCH_B;
          end else begin
            s_nxt.seq = S_EVAL;
          end
        end
      end
      S_FETCH_B: begin
        if (!s_r.req) begin
          ba = byte_addr(cur_v.p.origin, cur_v.p.wide, cur_pos, 1'b1);
          s_nxt.req = 1'b1;
          s_nxt.addr = ba[16:1];
          s_nxt.lane = ba[0];
        end else if (rom_ack) begin
          s_nxt.req = 1'b0;
          s_nxt.nib = cur_pos[0] ? got[3:0] : got[7:4];
          s_nxt.seq = S_EVAL;
        end
      end
      S_EVAL: begin
        s_nxt.acc = s_r.acc + 16'(contrib);
        s_nxt.v[s_r.cur].phase = cur_v.phase +
          (PW'(cur_v.p.pitch) << cur_v.p.oct);
        to_next = 1'b1;
      end
      S_DONE: begin
        s_nxt.mix = s_r.acc;
        s_nxt.seq = S_IDLE;
      end
      default: s_nxt.seq = S_IDLE;
    endcase
    if (to_next) begin
      s_nxt.retried = 1'b0;
      if (s_r.cur == 3'h7) begin
        s_nxt.seq = S_DONE;
      end else begin
        s_nxt.cur = s_r.cur + 3'h1;
        s_nxt.seq = S_FETCH_A;
      end
    end
    // Trigger overrides the sequencer's update of the same voice
    if (trig.valid) begin
      unique case (trig.mode)
        wte_pkg::UPD_PITCH: begin
          s_nxt.v[trig.voice].p.pitch = param.pitch;
          s_nxt.v[trig.voice].p.oct = param.oct;
        end
        wte_pkg::UPD_VOL: begin
          s_nxt.v[trig.voice].p.atten = param.atten;
        end
        wte_pkg::UPD_ALL, wte_pkg::UPD_RSVD: begin
          s_nxt.v[trig.voice].p = param;
          s_nxt.v[trig.voice].phase = '0;
        end
      endcase
      s_nxt.v[trig.voice].active = 1'b1;
    end
  end

  // State register; the clock enable freezes everything
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign rom_req = s_r.req;
  assign rom_addr = s_r.addr;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  origin_align_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    rom_req && s_r.seq == S_FETCH_A && cur_pos == 16'h0000 |->
    rom_addr == {cur_v.p.origin, 5'h00})
    else $error("first fetch not at origin times 32");
  unit_step_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    s_r.seq == S_EVAL && cur_v.p.pitch == 12'h800 && cur_v.p.oct == 4'h6
    && !trig.valid |->
    s_nxt.v[s_r.cur].phase == cur_v.phase + 33'h0_0002_0000)
    else $error("unit pitch does not step one sample");
  end_jump_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ce && s_r.seq == S_FETCH_A && s_r.req && rom_ack && !trig.valid &&
    got == wte_pkg::END_CODE && !s_r.retried |=>
    cur_pos == $past(loop_tgt) && s_r.retried ##1 (!$past(ce) || rom_req))
    else $error("end code did not jump to loop point");
  vol_only_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ce && trig.valid && trig.mode == wte_pkg::UPD_VOL |=>
    s_r.v[$past(trig.voice)].p.atten == $past(param.atten) &&
    s_r.v[$past(trig.voice)].p.pitch ==
    $past(s_r.v[trig.voice].p.pitch))
    else $error("volume-only update touched pitch");
  full_scale_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    s_r.seq == S_EVAL && !cur_v.p.wide && cur_v.p.atten == 10'h000 &&
    s_r.byte_a == 8'h7f |-> contrib == 14'h0fdc)
    else $error("full-scale attenuation wrong");
  mix_out_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ce && s_r.seq == S_DONE ##1 ce |-> ##1 dac_word == $past(s_r.mix) ||
    !$past(dac_cfg.src))
    else $error("mix not delivered to converter");
endmodule : wte_synth
`default_nettype wire

// *** test/testbench.sv ***
/*
 * Self-checking bench for the voice engine top with a ROM model.
 * Assumes inputs change 1 ns after each rising edge of ref_clk.
 */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PER = 64; // Short sample period keeps the run brief
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic fill_on = 1'b0;
  logic rom_req, rom_ack, dac_on;
  logic [7:0] bus_rdata, v, d;
  logic [7:0] fill = 8'h00;
  logic [15:0] rom_addr, rom_data, dac_word, last_a, base;
  logic [11:0] smp;
  logic [9:0] att, lp;
  logic [10:0] org;
  wte_pkg::wte_bus_t bus = '0;
  int error_cnt = 0;
  int total_checks = 0;
  int n_fetch = 0;
  int t = 0;
  logic [7:0] ra [12] = '{8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h21, 8'h22,
                          8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h2a};
  logic [7:0] rm [12] = '{8'hff, 8'hff, 8'h03, 8'hc7, 8'hff, 8'hff,
                          8'h07, 8'hff, 8'h83, 8'hff, 8'h03, 8'hff};
  wte_synth #(.SAMPLE_PERIOD(PER)) uut (.ref_clk(ref_clk),
    .arst_n(arst_n), .ce(ce), .bus(bus), .bus_rdata(bus_rdata),
    .rom_req(rom_req), .rom_addr(rom_addr), .rom_ack(rom_ack),
    .rom_data(rom_data), .dac_on(dac_on), .dac_word(dac_word));
  wte_rom_model rom (.ref_clk(ref_clk), .rom_req(rom_req),
    .rom_addr(rom_addr), .rom_ack(rom_ack), .rom_data(rom_data),
    .fill_on(fill_on), .fill(fill));
  always #2.5 ref_clk = ~ref_clk;
  // Last fetch address and count of answered fetches
  always @(posedge ref_clk) if (rom_req) last_a <= rom_addr;
  always @(posedge ref_clk) if (rom_req && rom_ack) n_fetch <= n_fetch + 1;
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] dat);
    bus = '{a, dat, 1'b1, 1'b0};
    cyc(1);
    bus.we = 1'b0;
    cyc(1); // Idle edge so the next call never re-drives in this step
  endtask : wr
  // Read data is registered, so take it one edge after the strobe
  task automatic rd(input logic [7:0] a);
    bus = '{a, 8'h00, 1'b0, 1'b1};
    cyc(1);
    bus.re = 1'b0;
    cyc(1);
    v = bus_rdata;
  endtask : rd
  task automatic rst();
    if (t > 0) $display("test %0d done", t);
    t++;
    arst_n = 1'b0;
    cyc(4);
    arst_n = 1'b1;
  endtask : rst
  // Voice select goes last because it starts playback
  task automatic setup(input logic [2:0] vc, input logic [11:0] p,
      input logic [9:0] a, input logic w, input logic [1:0] md);
    wr(8'h21, {4'h6, p[11:8]});
    wr(8'h22, p[7:0]);
    wr(8'h23, {5'h0, org[10:8]});
    wr(8'h24, org[7:0]);
    wr(8'h25, {w, 5'h0, lp[9:8]});
    wr(8'h26, lp[7:0]);
    wr(8'h27, {6'h0, a[9:8]});
    wr(8'h2a, a[7:0]);
    wr(8'h20, {md, 3'h0, vc});
  endtask : setup
  task automatic wait_req(input logic lvl);
    for (int i = 0; i < 4 * PER && rom_req !== lvl; i++) cyc(1);
  endtask : wait_req
  function automatic logic [15:0] mix_of(input logic [11:0] s,
      input logic [9:0] a, input int n);
    int p;
    p = ($signed(s) * (1023 - int'(a))) >>> 9;
    return 16'(p * n);
  endfunction : mix_of
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  initial begin
    #200000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    d = 8'($urandom(32'hb0a8e870));
    lp = 10'h000;
    rst();
    check("dac_on", dac_on, 0);
    rd(8'h1f);
    check("ctl reset", v, 0);
    for (int i = 0; i < 12; i++) begin
      d = 8'($urandom);
      wr(ra[i], d);
      rd(ra[i]);
      check("reg", v, d & rm[i]);
    end
    wr(8'h28, 8'hff);
    rd(8'h28);
    check("unmapped", v, 0);
    rst();
    wr(8'h1d, d);
    wr(8'h1e, ~d);
    wr(8'h1f, 8'h02);
    cyc(3);
    check("dac_on", dac_on, 1);
    check("word", dac_word, {d, ~d});
    ce = 1'b0;
    wr(8'h1e, d);
    ce = 1'b1;
    cyc(3);
    check("frozen", dac_word, {d, ~d});
    rst();
    org = 11'($urandom);
    setup(3'd5, 12'h000, 10'h000, 1'b0, 2'b00);
    wait_req(1'b1);
    check("origin", rom_addr, {org, 5'h0});
    wr(8'h27, 8'h03);
    wr(8'h2a, 8'hff);
    wr(8'h20, 8'h85);
    cyc(3 * PER);
    d = 8'(n_fetch);
    cyc(3 * PER);
    check("faded", 8'(n_fetch) - d, 0);
    rst();
    setup(3'd2, 12'h800, 10'h000, 1'b0, 2'b00);
    cyc(20 * PER);
    base = last_a - {org, 5'h0};
    check("step", 16'(base >= 9 && base <= 11), 1);
    for (int k = 0; k < 4; k++) begin
      rst();
      fill_on = 1'b1;
      fill = (k == 0) ? 8'h81 : 8'($urandom);
      if (fill == 8'h80) fill = 8'h7f;
      att = 10'($urandom_range(1022));
      smp = k[0] ? {fill, fill[7:4]} : {fill, 4'h0};
      for (int j = 0; j <= k; j++) setup(3'(j), 12'h000, att, k[0], 2'b00);
      wr(8'h1f, 8'h03);
      cyc(4 * PER);
      check("mix", dac_word, mix_of(smp, att, k + 1));
      setup(3'd0, 12'h000, 10'h000, k[0], 2'b01);
      cyc(4 * PER);
      check("pitch only", dac_word, mix_of(smp, att, k + 1));
      setup(3'd0, 12'h000, 10'h000, k[0], 2'b10);
      cyc(4 * PER);
      base = mix_of(smp, 10'h000, 1) + mix_of(smp, att, k);
      check("vol only", dac_word, base);
    end
    rst();
    fill = 8'h80;
    lp = 10'(-$urandom_range(1023, 1));
    wr(8'h1f, 8'h03);
    setup(3'd7, 12'h000, 10'h000, 1'b0, 2'b00);
    wait_req(1'b1);
    check("first", rom_addr, {org, 5'h0});
    wait_req(1'b0);
    wait_req(1'b1);
    base = {org, 5'h0} + 16'({6'h3f, lp} >> 1);
    check("loop", rom_addr, base);
    cyc(3 * PER);
    check("end code", dac_word, 0);
    $display("test %0d done", t);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire

// *** test/wte_rom_model.sv ***
/*
 * Shared program ROM model for the voice engine fetch port.
 * Assumes the engine holds each request until it sees the ack.
 */
`default_nettype none
module wte_rom_model (
  // Fetch port
  input wire logic ref_clk,
  input wire logic rom_req,
  input wire logic [15:0] rom_addr,
  output logic rom_ack,
  output logic [15:0] rom_data,
  // Uniform content select
  input wire logic fill_on,
  input wire logic [7:0] fill
);
  timeunit 1ns;
  timeprecision 100ps;
  int dly = 0;
  // ---------------------------------------------------------------
  // Answer
  // ---------------------------------------------------------------
  // Random 0..3 cycle delay; data toggles off the ack so stale reads fail
  always @(posedge ref_clk) begin
    #1;
    if (rom_ack || !rom_req) begin
      rom_ack = 1'b0;
      rom_data = ~rom_data;
      dly = $urandom_range(3);
    end else if (dly != 0) begin
      dly = dly - 1;
      rom_data = ~rom_data;
    end else begin
      rom_ack = 1'b1;
      rom_data = fill_on ? {fill, fill} :
                 {1'b0, rom_addr[6:0], 1'b0, rom_addr[14:8]};
    end
  end
  initial rom_ack = 1'b0;
  initial rom_data = 16'h5aa5;
endmodule : wte_rom_model
`default_nettype wire
